// >>> sbsr_top.sv
// status byte and service request block with its lower status groups
// Function
// (R1) request-service flag lives at status bit 6
// (R2) request starts on enabled rising summary only
// (R3) pending until serial poll; blocks new requests
// (R4) request drives bus line and flag together
// (R5) serial poll clears flag, other bits kept
// (R6) controller polls devices when line asserted
// (R7) status query returns byte, clears nothing
// (R8) status bits 0 and 1 read zero
// (R9) bit 2 set while error queue nonempty
// (R10) bit 3 is questionable group summary
// (R11) bit 4 is output queue data waiting
// (R12) bit 5 is standard event group summary
// (R13) bit 7 is operation group summary
// (R14) values are binary weighted bit sums
// (R15) mask written by command, query returns it
// (R16) mask resets to all zeros
// (R17) controller includes weight 64 when enabling
// (R18) condition bits follow inputs, no latching
// (R19) event bits sticky until read or clear
// (R20) filters preset rising; falling or both selectable
// (R21) flag stays until its cause clears
// (R22) controller stops continuous run before configuring
// (R23) summary is OR of event AND enable
// (R24) clear empties error queue, clears events
// (R25) reset clears pending interlock and flag
`timescale 1ns/1ps
module sbsr_top
   import sbsr_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   input  wire logic [15:0] ques_cond,
   input  wire logic [15:0] oper_cond,
   input  wire logic [7:0]  std_event_set,
   input  wire logic        err_queue_nonempty,
   input  wire logic        out_queue_ready,
   input  wire logic        cmd_valid,
   input  wire logic [3:0]  cmd_code,
   input  wire logic [1:0]  cmd_grp,
   input  wire logic [15:0] cmd_wdata,
   input  wire logic        serial_poll,
   output logic             srq_o,
   output logic             srq_oe,
   output logic [7:0]       poll_byte,
   output logic             poll_valid,
   output logic [15:0]      rsp_data,
   output logic             rsp_valid,
   output logic             err_queue_clear
);
   // =====================================================
   // pin synchronisers
   logic [15:0] ques_s1_r;
   logic [15:0] ques_s2_r;
   logic [15:0] oper_s1_r;
   logic [15:0] oper_s2_r;
   logic [7:0]  std_s1_r;
   logic [7:0]  std_s2_r;
   logic [1:0]  eq_s1_r;
   logic [1:0]  eq_s2_r;
   logic        poll_s1_r;
   logic        poll_s2_r;
   logic        poll_s3_r;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ques_s1_r <= '0;
         ques_s2_r <= '0;
         oper_s1_r <= '0;
         oper_s2_r <= '0;
         std_s1_r  <= '0;
         std_s2_r  <= '0;
         eq_s1_r   <= '0;
         eq_s2_r   <= '0;
         poll_s1_r <= 1'b0;
         poll_s2_r <= 1'b0;
         poll_s3_r <= 1'b0;
      end else if (clk_en) begin
         ques_s1_r <= ques_cond;  // see (R18)
         ques_s2_r <= ques_s1_r;
         oper_s1_r <= oper_cond;
         oper_s2_r <= oper_s1_r;
         std_s1_r  <= std_event_set;
         std_s2_r  <= std_s1_r;
         eq_s1_r   <= {out_queue_ready, err_queue_nonempty};
         eq_s2_r   <= eq_s1_r;
         poll_s1_r <= serial_poll;
         poll_s2_r <= poll_s1_r;
         poll_s3_r <= poll_s2_r;
      end
   end

   logic poll_evt;
   assign poll_evt = poll_s2_r & ~poll_s3_r;

   // =====================================================
   // command decode
   logic cmd_cls;
   logic [SBSR_NGRP-1:0] g_sel;
   assign cmd_cls = cmd_valid && cmd_code == SBSR_CMD_CLS;

   function automatic logic [SBSR_NGRP-1:0] grp_dec(input logic [1:0] s);
      grp_dec = '0;
      if (s < 2'(SBSR_NGRP)) grp_dec[s] = 1'b1;
   endfunction

   assign g_sel = cmd_valid ? grp_dec(cmd_grp) : '0;

   // =====================================================
   // status groups; the standard group has no condition filters,
   // so its inputs are treated as rising-edge event pulses
   sbsr_grp_if gi [SBSR_NGRP] ();
   logic [15:0] conds [SBSR_NGRP];
   assign conds[0] = ques_s2_r;
   assign conds[1] = oper_s2_r;
   assign conds[2] = {8'h00, std_s2_r};

   logic [SBSR_NGRP-1:0] sums;
   logic [15:0] evts [SBSR_NGRP];
   logic [15:0] ens  [SBSR_NGRP];

   genvar k;
   generate
      for (k = 0; k < SBSR_NGRP; k++) begin : g_grp
         assign gi[k].cond      = conds[k];
         assign gi[k].ptr_wdata = cmd_wdata;
         assign gi[k].ntr_wdata = cmd_wdata;
         assign gi[k].en_wdata  = cmd_wdata;
         assign gi[k].ptr_we    = g_sel[k] && cmd_code == SBSR_CMD_WPTR
                                  && k != SBSR_G_STD;
         assign gi[k].ntr_we    = g_sel[k] && cmd_code == SBSR_CMD_WNTR
                                  && k != SBSR_G_STD;
         assign gi[k].en_we     = g_sel[k] && cmd_code == SBSR_CMD_WEN;
         // reading an event register clears it  see (R19)
         assign gi[k].evt_clr   = cmd_cls
                                  || (g_sel[k] && cmd_code == SBSR_CMD_REVT);
         assign sums[k] = gi[k].summary;  // see (R23)
         assign evts[k] = gi[k].evt;
         assign ens[k]  = gi[k].en;
         sbsr_group u_grp (
            .ref_clk (ref_clk),
            .rst_n   (rst_n),
            .clk_en  (clk_en),
            .g       (gi[k])
         );
      end
   endgenerate

   // =====================================================
   // status byte and service request
   logic [7:0] mask_r;
   logic [7:0] mask_nxt;
   logic       rqs_r;
   logic       pend_r;
   logic [7:0] summ;
   logic [7:0] summ_q_r;
   logic       err_bit;
   logic       start_req;

   // bit 2 reads zero while the clear pulse to the error queue is out  see (R24)
   assign err_bit = eq_s2_r[0] & ~err_queue_clear;

   always_comb begin
      summ = '0;
      summ[SBSR_BIT_ERR]  = err_bit;               // see (R9)
      summ[SBSR_BIT_QUES] = sums[SBSR_G_QUES];     // see (R10)
      summ[SBSR_BIT_MAV]  = eq_s2_r[1];            // see (R11)
      summ[SBSR_BIT_ESB]  = sums[SBSR_G_STD];      // see (R12)
      summ[SBSR_BIT_OPER] = sums[SBSR_G_OPER];     // see (R13)
      summ = summ & ~SBSR_ZERO_MASK;               // see (R8)
   end

   // rising, enabled summary while nothing is pending  see (R2)
   assign start_req = |(summ & ~summ_q_r & mask_r) && !pend_r;

   assign mask_nxt = (cmd_valid && cmd_code == SBSR_CMD_WMASK)
                   ? (cmd_wdata[7:0] & ~SBSR_ZERO_MASK) : mask_r;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) mask_r <= SBSR_MASK_RST;  // see (R16)
      else if (clk_en) mask_r <= mask_nxt;  // see (R15)
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) summ_q_r <= '0;
      else if (clk_en) summ_q_r <= summ;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pend_r <= 1'b0;  // see (R25)
         rqs_r  <= 1'b0;
      end else if (clk_en) begin
         if (start_req) begin
            pend_r <= 1'b1;  // see (R3)
            rqs_r  <= 1'b1;  // see (R4)
         end else if (poll_evt) begin
            pend_r <= 1'b0;  // see (R3)
            rqs_r  <= 1'b0;  // see (R5)
         end else if (!(|(summ & mask_r))) begin
            rqs_r <= 1'b0;   // see (R21)
         end
      end
   end

   logic [7:0] stb;
   always_comb begin
      stb = summ;
      stb[SBSR_BIT_RQS] = rqs_r;  // see (R1)
   end

   // =====================================================
   // bus line and serial poll answer
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         srq_o  <= 1'b0;
         srq_oe <= 1'b0;
      end else if (clk_en) begin
         srq_o  <= 1'b0;
         srq_oe <= start_req || (pend_r && !poll_evt);  // see (R4)
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         poll_byte  <= '0;
         poll_valid <= 1'b0;
      end else if (clk_en) begin
         poll_valid <= poll_evt;
         if (poll_evt) poll_byte <= stb;  // see (R5)
      end
   end

   // =====================================================
   // command responses
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rsp_data        <= '0;
         rsp_valid       <= 1'b0;
         err_queue_clear <= 1'b0;
      end else if (clk_en) begin
         rsp_valid       <= 1'b0;
         err_queue_clear <= cmd_cls;  // see (R24)
         if (cmd_valid) begin
            case (cmd_code)
               SBSR_CMD_STBQ: begin
                  rsp_data  <= {8'h00, stb};  // see (R7) (R14)
                  rsp_valid <= 1'b1;
               end
               SBSR_CMD_RMASK: begin
                  rsp_data  <= {8'h00, mask_r};  // see (R15)
                  rsp_valid <= 1'b1;
               end
               SBSR_CMD_REN: begin
                  rsp_data  <= (cmd_grp < 2'(SBSR_NGRP)) ? ens[cmd_grp] : '0;
                  rsp_valid <= 1'b1;
               end
               SBSR_CMD_REVT: begin
                  rsp_data  <= (cmd_grp < 2'(SBSR_NGRP)) ? evts[cmd_grp] : '0;
                  rsp_valid <= 1'b1;
               end
               SBSR_CMD_RCOND: begin
                  rsp_data  <= (cmd_grp < 2'(SBSR_NGRP)) ? conds[cmd_grp] : '0;
                  rsp_valid <= 1'b1;
               end
               default: rsp_valid <= 1'b0;
            endcase
         end
      end
   end
endmodule

// >>> sbsr_pkg.sv
// package: status byte layout, command codes and reset values
package sbsr_pkg;
   localparam int          SBSR_BYTE_W    = 8;
   localparam int          SBSR_GRP_W     = 16;
   localparam int          SBSR_BIT_ERR   = 2;
   localparam int          SBSR_BIT_QUES  = 3;
   localparam int          SBSR_BIT_MAV   = 4;
   localparam int          SBSR_BIT_ESB   = 5;
   localparam int          SBSR_BIT_RQS   = 6;
   localparam int          SBSR_BIT_OPER  = 7;
   localparam logic [7:0]  SBSR_ZERO_MASK = 8'h03;
   localparam logic [7:0]  SBSR_MASK_RST  = 8'h00;
   localparam logic [15:0] SBSR_PTR_RST   = 16'hFFFF;
   localparam logic [15:0] SBSR_NTR_RST   = 16'h0000;
   localparam int          SBSR_NGRP      = 3;
   localparam logic [1:0]  SBSR_G_QUES    = 2'h0;
   localparam logic [1:0]  SBSR_G_OPER    = 2'h1;
   localparam logic [1:0]  SBSR_G_STD     = 2'h2;

   // host command codes on the command port
   typedef enum logic [3:0] {
      SBSR_CMD_NOP    = 4'h0,
      SBSR_CMD_CLS    = 4'h1,
      SBSR_CMD_WMASK  = 4'h2,
      SBSR_CMD_RMASK  = 4'h3,
      SBSR_CMD_STBQ   = 4'h4,
      SBSR_CMD_WEN    = 4'h5,
      SBSR_CMD_REN    = 4'h6,
      SBSR_CMD_WPTR   = 4'h7,
      SBSR_CMD_WNTR   = 4'h8,
      SBSR_CMD_REVT   = 4'h9,
      SBSR_CMD_RCOND  = 4'hA
   } sbsr_cmd_e;
endpackage

// >>> sbsr_grp_if.sv
// interface: one status group's controls toward the group module
`timescale 1ns/1ps
interface sbsr_grp_if;
   logic [15:0] cond;
   logic [15:0] ptr_wdata;
   logic [15:0] ntr_wdata;
   logic [15:0] en_wdata;
   logic        ptr_we;
   logic        ntr_we;
   logic        en_we;
   logic        evt_clr;
   logic [15:0] evt;
   logic [15:0] en;
   logic        summary;
   modport ctl (output cond, ptr_wdata, ntr_wdata, en_wdata, ptr_we,
                output ntr_we, en_we, evt_clr, input evt, en, summary);
   modport grp (input cond, ptr_wdata, ntr_wdata, en_wdata, ptr_we,
                input ntr_we, en_we, evt_clr, output evt, en, summary);
endinterface

// >>> sbsr_group.sv
// status group: condition, transition filters, event latch, summary
`timescale 1ns/1ps
module sbsr_group
   import sbsr_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic clk_en,
   sbsr_grp_if.grp   g
);
   logic [SBSR_GRP_W-1:0] cond_q_r;
   logic [SBSR_GRP_W-1:0] ptr_r;
   logic [SBSR_GRP_W-1:0] ntr_r;
   logic [SBSR_GRP_W-1:0] en_r;
   logic [SBSR_GRP_W-1:0] evt_r;
   logic [SBSR_GRP_W-1:0] hit;
   logic                  sum_r;

   // =====================================================
   // filters and enable
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ptr_r <= SBSR_PTR_RST;  // see (R20)
         ntr_r <= SBSR_NTR_RST;
         en_r  <= '0;
      end else if (clk_en) begin
         if (g.ptr_we) ptr_r <= g.ptr_wdata;
         if (g.ntr_we) ntr_r <= g.ntr_wdata;
         if (g.en_we)  en_r  <= g.en_wdata;
      end
   end

   // =====================================================
   // edge capture and event latch
   assign hit = (g.cond & ~cond_q_r & ptr_r)
              | (~g.cond & cond_q_r & ntr_r);  // see (R20)

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cond_q_r <= '0;
         evt_r    <= '0;
      end else if (clk_en) begin
         cond_q_r <= g.cond;
         // new edge wins over a clear in the same cycle
         evt_r <= (g.evt_clr ? '0 : evt_r) | hit;  // see (R19)
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) sum_r <= 1'b0;
      else if (clk_en) sum_r <= |(((g.evt_clr ? '0 : evt_r) | hit)
                                  & (g.en_we ? g.en_wdata : en_r));  // see (R23)
   end

   assign g.evt     = evt_r;
   assign g.en      = en_r;
   assign g.summary = sum_r;
endmodule

// >>> sbsr_top_chk.sv
// checker: port-level properties of the status byte block
`timescale 1ns/1ps
module sbsr_top_chk
   import sbsr_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic        clk_en,
   input wire logic        cmd_valid,
   input wire logic [3:0]  cmd_code,
   input wire logic [15:0] cmd_wdata,
   input wire logic        serial_poll,
   input wire logic        srq_o,
   input wire logic        srq_oe,
   input wire logic [7:0]  poll_byte,
   input wire logic        poll_valid,
   input wire logic [15:0] rsp_data,
   input wire logic        rsp_valid,
   input wire logic        err_queue_clear
);
   logic [7:0] mask_r;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // ==========================================
   // shadow of the request mask
   always_ff @(posedge ref_clk) begin
      if (!rst_n)
         mask_r <= 8'h00;
      else if (clk_en && cmd_valid && cmd_code == SBSR_CMD_WMASK)
         mask_r <= cmd_wdata[7:0];
   end
   // ==========================================
   // properties
   sequence s_poll_req;
      $rose(serial_poll);
   endsequence
   sequence s_poll_ans;
      ##[2:6] poll_valid;
   endsequence
   a_poll_answer: assert property (s_poll_req |-> s_poll_ans)
      else $error("serial poll not answered");
   a_srq_cause: assert property ($rose(srq_oe) |-> (mask_r & 8'hBC) != 8'h00)
      else $error("request without enabled bit");
   a_srq_hold: assert property ($fell(srq_oe) |-> poll_valid || $past(poll_valid))
      else $error("request dropped without poll");
   a_srq_release: assert property (poll_valid |=> !srq_oe)
      else $error("request kept after poll");
   a_poll_rqs: assert property (poll_valid && $past(srq_oe) |-> poll_byte[SBSR_BIT_RQS])
      else $error("polled byte lacks request flag");
   a_poll_low: assert property (poll_valid |-> poll_byte[1:0] == 2'h0)
      else $error("polled low bits not zero");
   a_rsp_cause: assert property (rsp_valid |-> $past(cmd_valid && clk_en))
      else $error("answer without command");
   a_mask_bits: assert property (rsp_valid && $past(cmd_code) == SBSR_CMD_RMASK |-> rsp_data[15:8] == 8'h00 && rsp_data[1:0] == 2'h0)
      else $error("mask answer out of range");
   a_cls_pulse: assert property (cmd_valid && clk_en && cmd_code == SBSR_CMD_CLS |=> err_queue_clear)
      else $error("clear pulse missing");
   a_clr_cause: assert property (err_queue_clear |-> $past(cmd_valid && cmd_code == SBSR_CMD_CLS))
      else $error("clear pulse without command");
   a_srq_wire: assert property (srq_o == 1'b0)
      else $error("request pin driven high");
endmodule
bind sbsr_top sbsr_top_chk u_chk (.*);

// >>> sbsr_ctl_model.sv
// model: bus controller answering service requests by serial poll
`timescale 1ns/1ps
module sbsr_ctl_model (
   input  wire logic       ref_clk,
   input  wire logic       srq_line_n,
   input  wire logic       poll_valid,
   input  wire logic [7:0] poll_byte,
   output logic            serial_poll,
   output logic [7:0]      polled_byte,
   output int              poll_cnt
);
   logic got;
   initial begin
      serial_poll = 1'b0;
      polled_byte = 8'h00;
      poll_cnt    = 0;
      forever begin
         @(negedge ref_clk);
         if (srq_line_n === 1'b0) begin
            repeat (20) @(negedge ref_clk);
            serial_poll = 1'b1;
            got = 1'b0;
            // hold the poll until the byte comes back
            for (int i = 0; i < 20 && !got; i++) begin
               @(negedge ref_clk);
               if (poll_valid === 1'b1) begin
                  got = 1'b1;
                  polled_byte = poll_byte;
                  poll_cnt++;
               end
            end
            @(negedge ref_clk);
            serial_poll = 1'b0;
         end
      end
   end
endmodule

// >>> testbench.sv
// testbench: status byte, group and service request scenarios
`timescale 1ns/1ps
module testbench;
   import sbsr_pkg::*;
   logic ref_clk, rst_n, cmd_valid, err_q, out_q, serial_poll, clk_en;
   logic srq_o, srq_oe, poll_valid, rsp_valid, eq_clr, rv, eqc;
   logic [15:0] ques_cond, oper_cond, cmd_wdata, rsp_data, rs;
   logic [7:0]  std_set, poll_byte, pb;
   logic [3:0]  cmd_code;
   logic [1:0]  cmd_grp;
   wire         srq_n = srq_oe ? srq_o : 1'b1;
   int          mismatches, total_checks, pcnt;
   sbsr_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
      .ques_cond(ques_cond), .oper_cond(oper_cond),
      .std_event_set(std_set), .err_queue_nonempty(err_q),
      .out_queue_ready(out_q), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_grp(cmd_grp), .cmd_wdata(cmd_wdata),
      .serial_poll(serial_poll), .srq_o(srq_o), .srq_oe(srq_oe),
      .poll_byte(poll_byte), .poll_valid(poll_valid),
      .rsp_data(rsp_data), .rsp_valid(rsp_valid),
      .err_queue_clear(eq_clr));
   sbsr_ctl_model u_ctl (.ref_clk(ref_clk), .srq_line_n(srq_n),
      .poll_valid(poll_valid), .poll_byte(poll_byte),
      .serial_poll(serial_poll), .polled_byte(pb), .poll_cnt(pcnt));
   // ==========================================
   // helpers
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wt(int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic cmd(logic [3:0] c, logic [1:0] g, logic [15:0] d);
      @(negedge ref_clk);
      cmd_valid = 1'b1;
      cmd_code  = c;
      cmd_grp   = g;
      cmd_wdata = d;
      // answer pulses stand for one cycle after the taking edge
      @(negedge ref_clk);
      rs  = rsp_data;
      rv  = rsp_valid;
      eqc = eq_clr;
      cmd_valid = 1'b0;
   endtask
   task automatic q(logic [3:0] c, logic [1:0] g, logic [15:0] e);
      cmd(c, g, 16'h0000);
      chk("rsp_valid", 16'h0001, {15'h0000, rv});
      chk($sformatf("rsp cmd %0h", c), e, rs);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ==========================================
   // scenarios
   task automatic t_rst;
      q(SBSR_CMD_RMASK, 2'h0, 16'h0000);
      q(SBSR_CMD_STBQ, 2'h0, 16'h0000);
      chk("srq_oe", 16'h0000, {15'h0000, srq_oe});
      $display("test reset done");
   endtask
   task automatic t_map;
      err_q = 1'b1;
      wt(6);
      q(SBSR_CMD_STBQ, 2'h0, 16'h0004);
      err_q = 1'b0;
      out_q = 1'b1;
      wt(6);
      q(SBSR_CMD_STBQ, 2'h0, 16'h0010);
      out_q = 1'b0;
      cmd(SBSR_CMD_WEN, SBSR_G_QUES, 16'h0001);
      cmd(SBSR_CMD_WEN, SBSR_G_OPER, 16'h0008);
      cmd(SBSR_CMD_WEN, SBSR_G_STD, 16'h0001);
      ques_cond = 16'h0001;
      oper_cond = 16'h0008;
      err_q = 1'b1;
      wt(6);
      q(SBSR_CMD_RCOND, SBSR_G_QUES, 16'h0001);
      q(SBSR_CMD_STBQ, 2'h0, 16'h008C);
      std_set = 8'h01;
      wt(6);
      q(SBSR_CMD_STBQ, 2'h0, 16'h00AC);
      std_set = 8'h00;
      q(SBSR_CMD_REVT, SBSR_G_STD, 16'h0001);
      q(SBSR_CMD_STBQ, 2'h0, 16'h008C);
      ques_cond = 16'h0000;
      wt(6);
      q(SBSR_CMD_RCOND, SBSR_G_QUES, 16'h0000);
      q(SBSR_CMD_STBQ, 2'h0, 16'h008C);
      q(SBSR_CMD_REVT, SBSR_G_QUES, 16'h0001);
      q(SBSR_CMD_STBQ, 2'h0, 16'h0084);
      $display("test map done");
   endtask
   task automatic t_flt;
      cmd(SBSR_CMD_WPTR, SBSR_G_QUES, 16'hFFFD);
      cmd(SBSR_CMD_WNTR, SBSR_G_QUES, 16'h0002);
      ques_cond = 16'h0002;
      wt(6);
      q(SBSR_CMD_REVT, SBSR_G_QUES, 16'h0000);
      ques_cond = 16'h0000;
      wt(6);
      q(SBSR_CMD_REVT, SBSR_G_QUES, 16'h0002);
      cmd(SBSR_CMD_WPTR, SBSR_G_QUES, 16'hFFFF);
      ques_cond = 16'h0002;
      wt(6);
      q(SBSR_CMD_REVT, SBSR_G_QUES, 16'h0002);
      ques_cond = 16'h0000;
      wt(6);
      $display("test filter done");
   endtask
   task automatic t_srq;
      cmd(SBSR_CMD_WMASK, 2'h0, 16'h0068);
      ques_cond = 16'h0001;
      for (int i = 0; i < 20 && srq_oe !== 1'b1; i++) wt(1);
      chk("srq_oe", 16'h0001, {15'h0000, srq_oe});
      q(SBSR_CMD_STBQ, 2'h0, 16'h00CC);
      q(SBSR_CMD_STBQ, 2'h0, 16'h00CC);
      std_set = 8'h01;
      wt(6);
      for (int i = 0; i < 80 && pcnt == 0; i++) wt(1);
      chk("polls", 16'h0001, pcnt[15:0]);
      chk("poll_byte", 16'h00EC, {8'h00, pb});
      wt(4);
      chk("srq_oe", 16'h0000, {15'h0000, srq_oe});
      q(SBSR_CMD_STBQ, 2'h0, 16'h00AC);
      $display("test request done");
   endtask
   task automatic t_cls;
      ques_cond = 16'h0000;
      std_set   = 8'h00;
      wt(6);
      cmd(SBSR_CMD_CLS, 2'h0, 16'h0000);
      chk("err_clr", 16'h0001, {15'h0000, eqc});
      err_q = 1'b0;
      wt(6);
      q(SBSR_CMD_STBQ, 2'h0, 16'h0000);
      q(SBSR_CMD_RMASK, 2'h0, 16'h0068);
      cmd(SBSR_CMD_WMASK, 2'h0, 16'h00FF);
      q(SBSR_CMD_RMASK, 2'h0, 16'h00FC);
      // a write while the clock enable is low must be ignored
      wt(2);
      clk_en = 1'b0;
      cmd(SBSR_CMD_WMASK, 2'h0, 16'h0000);
      clk_en = 1'b1;
      q(SBSR_CMD_RMASK, 2'h0, 16'h00FC);
      $display("test clear done");
   endtask
   // ==========================================
   // clock, watchdog, main sequence
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   initial begin
      #200000;
      mismatches++;
      finish_test;
   end
   initial begin
      {rst_n, cmd_valid, err_q, out_q} = 4'h0;
      {ques_cond, oper_cond, cmd_wdata} = 48'h0;
      {std_set, cmd_code, cmd_grp} = 14'h0;
      clk_en = 1'b1;
      mismatches = 0;
      total_checks = 0;
      wt(10);
      rst_n = 1'b1;
      t_rst;
      t_map;
      t_flt;
      t_srq;
      t_cls;
      finish_test;
   end
endmodule
